// *** rtl/pmp_mac_port.sv ***
// mac-facing nibble/dibit data port of the transceiver
`timescale 1ns/1ps
module pmp_mac_port #(
    parameter int FIFO_DEPTH = pmp_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       sys_clk_in,
    input  wire logic       srst_in,
    // configuration
    input  wire logic [2:0] cfg_strap_in,
    input  wire logic       ref50_sel_in,
    input  wire logic       xtal_is_50m_in,
    input  wire logic       eee_en_in,
    input  wire logic       full_duplex_in,
    input  wire logic       link_up_in,
    input  wire logic       speed_100_in,
    // mac transmit
    input  wire logic       tx_en_in,
    input  wire logic [3:0] tx_data_in,
    input  wire logic       tx_err_in,
    output logic            tx_clk_out,
    // mac receive
    output logic            rx_clk_out,
    output logic            rx_dv_out,
    output logic [3:0]      rx_data_out,
    output logic            rx_err_out,
    output logic            crs_out,
    output logic            col_out,
    output logic            ref_clk_out,
    // mode status
    output logic            rmii_mode_out,
    output logic            ref50_mode_out,
    output logic            rx_clk_recov_out,
    // line receive
    input  wire logic       ln_rx_valid_in,
    input  wire logic [2:0] ln_rx_kind_in,
    input  wire logic [3:0] ln_rx_nib_in,
    input  wire logic       ln_rx_err_in,
    input  wire logic       ln_rx_sfd_in,
    input  wire logic       ln_rec_tick_in,
    output logic            ln_rx_ready_out,
    // line transmit
    output logic            ln_tx_valid_out,
    output logic [3:0]      ln_tx_nib_out,
    output logic            ln_tx_lpi_out
);
    // mode capture
    logic        cap_done_r;
    logic [2:0]  strap_r;
    logic        rmii_r;
    logic        ref50_r;
    // speed and clocks
    logic        link_q_r;
    logic        speed_r;
    logic        recov_r;
    logic        tx_lvl;
    logic        tx_rise;
    logic        tx_fall;
    logic        rx_lvl;
    logic        rx_rise;
    logic        rx_fall;
    // receive line side
    pmp_pkg::pmp_rx_state_type st_r;
    pmp_pkg::pmp_rx_state_type st_nxt;
    logic        lpi_r;
    // receive mac side
    logic        half_r;
    // transmit
    logic        tx_half_r;
    logic [1:0]  tx_lo_r;
    logic        tx_act_r;

    pmp_strm_if #(.W(pmp_pkg::FW_W)) wr_if ();
    pmp_strm_if #(.W(pmp_pkg::FW_W)) rd_if ();

    // configuration
    // straps caught once after reset
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cap_done_r <= 1'b0;
            strap_r    <= pmp_pkg::STRAP_MII;
        end else if (!cap_done_r) begin
            cap_done_r <= 1'b1;
            strap_r    <= cfg_strap_in;
        end
    end

    // other strap codes fall back to mii
    wire rmii_sel  = (strap_r == pmp_pkg::STRAP_RMII); // see RULE20
    wire ref50_sel = rmii_sel && ref50_sel_in && xtal_is_50m_in; // see RULE19

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rmii_r <= 1'b0;
            ref50_r <= 1'b0;
        end else begin
            rmii_r  <= rmii_sel;                // see RULE17
            ref50_r <= ref50_sel;               // see RULE18
        end
    end

    // speed and clocks
    wire link_rise = link_up_in && !link_q_r;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            link_q_r <= 1'b0;
            speed_r  <= 1'b0;
        end else begin
            link_q_r <= link_up_in;
            if (link_rise) begin
                speed_r <= speed_100_in;        // see RULE21
            end
        end
    end

    wire [pmp_pkg::DIV_W-1:0] div_sel =
        speed_r ? pmp_pkg::DIV_100 : pmp_pkg::DIV_10; // see RULE1

    // cdr tick resyncs the recovered phase
    wire recov_nxt = link_up_in && (speed_r || st_r != pmp_pkg::RX_IDLE);
    wire rx_sync   = recov_r && ln_rec_tick_in; // see RULE6 RULE7

    pmp_clkgen #(.DIV_W(pmp_pkg::DIV_W)) u_txgen (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .div_in     (div_sel),
        .sync_in    (1'b0),
        .lvl_out    (tx_lvl),
        .rise_out   (tx_rise),
        .fall_out   (tx_fall)
    );

    pmp_clkgen #(.DIV_W(pmp_pkg::DIV_W)) u_rxgen (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .div_in     (div_sel),
        .sync_in    (rx_sync),
        .lvl_out    (rx_lvl),
        .rise_out   (rx_rise),
        .fall_out   (rx_fall)
    );

    // rmii: a dibit per nibble-clock edge
    wire tx_tick = rmii_r ? (tx_rise || tx_fall) : tx_rise;
    wire rx_tick = rmii_r ? (rx_rise || rx_fall) : rx_fall;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            tx_clk_out       <= 1'b0;
            rx_clk_out       <= 1'b0;
            ref_clk_out      <= 1'b0;
            recov_r          <= 1'b0;
            rx_clk_recov_out <= 1'b0;
            rmii_mode_out    <= 1'b0;
            ref50_mode_out   <= 1'b0;
        end else begin
            tx_clk_out       <= !rmii_r && tx_lvl;          // see RULE1
            rx_clk_out       <= !rmii_r && rx_lvl;          // see RULE8
            ref_clk_out      <= rmii_r && !ref50_r && tx_lvl;
            recov_r          <= recov_nxt;
            rx_clk_recov_out <= recov_nxt;
            rmii_mode_out    <= rmii_r;
            ref50_mode_out   <= ref50_r;
        end
    end

    // receive, line side
    wire take      = ln_rx_valid_in && wr_if.ready;
    wire k_data    = (ln_rx_kind_in == pmp_pkg::KIND_DATA);
    wire k_jk      = (ln_rx_kind_in == pmp_pkg::KIND_JK);
    wire k_end     = (ln_rx_kind_in == pmp_pkg::KIND_TR) ||
                     (ln_rx_kind_in == pmp_pkg::KIND_IDLE);
    wire k_lpi     = (ln_rx_kind_in == pmp_pkg::KIND_LPI);
    wire sfd_first = ln_rx_sfd_in && (ln_rx_nib_in == pmp_pkg::SFD_FIRST_NIB);

    always_comb begin
        st_nxt = st_r;
        if (!link_up_in) begin
            st_nxt = pmp_pkg::RX_IDLE;
        end else if (take) begin
            case (st_r)
                pmp_pkg::RX_IDLE: begin
                    if (speed_r && k_jk) begin
                        st_nxt = pmp_pkg::RX_FRM;       // see RULE15
                    end else if (!speed_r && k_data) begin
                        st_nxt = sfd_first ? pmp_pkg::RX_FRM
                                           : pmp_pkg::RX_PRE; // see RULE14
                    end
                end
                pmp_pkg::RX_PRE: begin
                    if (k_end) begin
                        st_nxt = pmp_pkg::RX_IDLE;
                    end else if (k_data && sfd_first) begin
                        st_nxt = pmp_pkg::RX_FRM;       // see RULE9
                    end
                end
                pmp_pkg::RX_FRM: begin
                    if (k_end) begin
                        st_nxt = pmp_pkg::RX_IDLE;      // see RULE15
                    end
                end
                default: st_nxt = pmp_pkg::RX_IDLE;
            endcase
        end
    end

    // 10M holds back preamble
    wire push_data = take && k_data &&
                     (st_nxt == pmp_pkg::RX_FRM); // see RULE10
    wire push_eof  = take && k_end && (st_r == pmp_pkg::RX_FRM);

    assign wr_if.valid = push_data || push_eof;
    assign wr_if.data  = {push_eof, ln_rx_err_in && k_data, ln_rx_nib_in};

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st_r    <= pmp_pkg::RX_IDLE;
            lpi_r   <= 1'b0;
            crs_out <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            crs_out <= (st_nxt != pmp_pkg::RX_IDLE); // see RULE14 RULE15
            if (!eee_en_in || !link_up_in) begin
                lpi_r <= 1'b0;
            end else if (take) begin
                lpi_r <= k_lpi;
            end
        end
    end

    assign ln_rx_ready_out = wr_if.ready;

    pmp_fifo #(.W(pmp_pkg::FW_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk_in (sys_clk_in),
        .srst_in    (srst_in),
        .wr         (wr_if.snk),
        .rd         (rd_if.src)
    );

    // receive, mac side
    wire       w_eof = rd_if.data[pmp_pkg::FW_EOF_BIT];
    wire       w_err = rd_if.data[pmp_pkg::FW_ERR_BIT];
    wire [3:0] w_nib = rd_if.data[pmp_pkg::FW_NIB_LSB +: pmp_pkg::NIB_W];
    wire       have  = rd_if.valid;
    // rmii pops after the high dibit
    wire       done  = w_eof || !rmii_r || half_r;

    assign rd_if.ready = rx_tick && have && done;

    wire [3:0] out_nib = rmii_r ? {2'b00, half_r ? w_nib[3:2] : w_nib[1:0]}
                                : w_nib;
    wire       lpi_eee = eee_en_in && lpi_r;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rx_dv_out   <= 1'b0;
            rx_data_out <= pmp_pkg::IDLE_NIB;
            rx_err_out  <= 1'b0;
            half_r      <= 1'b0;
        end else if (rx_tick) begin
            if (have && !w_eof) begin
                rx_dv_out   <= 1'b1;                    // see RULE11
                rx_data_out <= out_nib;
                rx_err_out  <= w_err;                   // see RULE12
                half_r      <= rmii_r && !half_r;
            end else if (have || !rx_dv_out) begin
                rx_dv_out   <= 1'b0;
                rx_data_out <= pmp_pkg::idle_nib(lpi_eee); // see RULE11
                rx_err_out  <= lpi_eee;                 // see RULE13
                half_r      <= 1'b0;
            end else begin
                // starved mid-frame: flag lost nibble
                rx_err_out  <= 1'b1;                    // see RULE12
            end
        end
    end

    // transmit
    // mac lines settle before our sample
    wire tx_lpi_req = eee_en_in && !tx_en_in &&
        (tx_err_in || tx_data_in == pmp_pkg::LPI_NIB); // see RULE4 RULE5

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            ln_tx_valid_out <= 1'b0;
            ln_tx_nib_out   <= pmp_pkg::IDLE_NIB;
            ln_tx_lpi_out   <= 1'b0;
            tx_half_r       <= 1'b0;
            tx_lo_r         <= 2'b00;
            tx_act_r        <= 1'b0;
        end else begin
            ln_tx_valid_out <= 1'b0;
            if (tx_tick) begin
                tx_act_r      <= tx_en_in;              // see RULE2
                ln_tx_lpi_out <= tx_lpi_req;
                if (!tx_en_in) begin
                    tx_half_r <= 1'b0;
                end else if (rmii_r && !tx_half_r) begin
                    tx_lo_r   <= tx_data_in[1:0];
                    tx_half_r <= 1'b1;
                end else begin
                    ln_tx_valid_out <= 1'b1;            // see RULE3
                    ln_tx_nib_out   <= rmii_r ?
                        {tx_data_in[1:0], tx_lo_r} : tx_data_in; // see RULE17
                    tx_half_r       <= 1'b0;
                end
            end
        end
    end

    // rmii mac rebuilds collision
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            col_out <= 1'b0;
        end else begin
            col_out <= !rmii_r && !full_duplex_in && link_up_in &&
                       tx_act_r && (st_r != pmp_pkg::RX_IDLE); // see RULE16
        end
    end
endmodule : pmp_mac_port

// *** rtl/pmp_pkg.sv ***
// constants and types of the mac-side port
// Behaviour
// RULE1: transmit clock runs continuously at link speed
// RULE2: mac frames transmit enable on clock edges
// RULE3: enabled transmit nibbles are taken for line
// RULE4: mac idles transmit data with idle or lpi
// RULE5: transmit error only requests low-power idle
// RULE6: 10M receive clock recovered only during carrier
// RULE7: 100M receive clock recovered while link up
// RULE8: receive clock runs at link speed rate
// RULE9: 10M valid rises with first delimiter nibble
// RULE10: 100M valid spans preamble through last nibble
// RULE11: one nibble per clock, else idle code
// RULE12: receive error flags coding errors in frame
// RULE13: eee receive error shows lpi while idle
// RULE14: 10M carrier follows preamble and end marker
// RULE15: 100M carrier follows start, end, idle symbols
// RULE16: half-duplex collision when transmit and receive
// RULE17: reduced-pin variant moves dibits per edge
// RULE18: strap 001 with select 0 gives 25M mode
// RULE19: strap 001 with select 1 gives 50M mode; code also needs xtal_is_50m_in set, else stays in 25M mode
// RULE20: strap 000 gives nibble-wide interface
// RULE21: clock rate changes only at link up
package pmp_pkg;
    localparam int SYS_CLK_KHZ  = 125000;
    localparam int NIB_10_KHZ   = 2500;
    localparam int NIB_100_KHZ  = 25000;
    localparam int DIV_W        = 6;
    localparam logic [DIV_W-1:0] DIV_10  =
        DIV_W'(SYS_CLK_KHZ / NIB_10_KHZ);
    localparam logic [DIV_W-1:0] DIV_100 =
        DIV_W'(SYS_CLK_KHZ / NIB_100_KHZ);
    localparam int NIB_W        = 4;
    localparam logic [3:0] IDLE_NIB      = 4'h0;
    localparam logic [3:0] LPI_NIB       = 4'h1;
    localparam logic [3:0] SFD_FIRST_NIB = 4'h5;
    localparam int STRAP_W      = 3;
    localparam logic [2:0] STRAP_MII  = 3'h0;
    localparam logic [2:0] STRAP_RMII = 3'h1;
    localparam int FW_NIB_LSB   = 0;
    localparam int FW_ERR_BIT   = 4;
    localparam int FW_EOF_BIT   = 5;
    localparam int FW_W         = 6;
    localparam int FIFO_DEPTH   = 32;
    typedef enum logic [2:0] {
        KIND_DATA = 3'h0,
        KIND_JK   = 3'h1,
        KIND_TR   = 3'h2,
        KIND_IDLE = 3'h3,
        KIND_LPI  = 3'h4
    } pmp_kind_type;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_PRE  = 2'h1,
        RX_FRM  = 2'h3
    } pmp_rx_state_type;

    function automatic logic [3:0] idle_nib(input logic lpi);
        idle_nib = lpi ? LPI_NIB : IDLE_NIB;
    endfunction : idle_nib
endpackage : pmp_pkg

// *** rtl/pmp_strm_if.sv ***
// valid/ready word stream between the port's own modules
`timescale 1ns/1ps
interface pmp_strm_if #(parameter int W = 6);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pmp_strm_if

// *** rtl/pmp_fifo.sv ***
// synchronous fifo with registered ready on the fill side
`timescale 1ns/1ps
module pmp_fifo #(
    parameter int W     = 6,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic  sys_clk_in,
    input  wire logic  srst_in,
    // streams
    pmp_strm_if.snk    wr,
    pmp_strm_if.src    rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          rdy_r;

    wire push = wr.valid && rdy_r;
    wire pop  = rd.ready && (cnt_r != '0);

    assign cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign wr.ready = rdy_r;
    assign rd.valid = (cnt_r != '0);
    assign rd.data  = mem[rp_r];

    always_ff @(posedge sys_clk_in) begin
        if (push) begin
            mem[wp_r] <= wr.data;
        end
    end

    // ready is registered so the line sees a flop
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
        end else begin
            wp_r  <= push ? AW'(wp_r + 1'b1) : wp_r;
            rp_r  <= pop ? AW'(rp_r + 1'b1) : rp_r;
            cnt_r <= cnt_nxt;
            rdy_r <= (cnt_nxt != FULL_CNT);
        end
    end
endmodule : pmp_fifo

// *** rtl/pmp_clkgen.sv ***
// divider making a port clock level and its edge pulses
`timescale 1ns/1ps
module pmp_clkgen #(
    parameter int DIV_W = 6
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             srst_in,
    // control
    input  wire logic [DIV_W-1:0] div_in,
    input  wire logic             sync_in,
    // outputs
    output logic                  lvl_out,
    output logic                  rise_out,
    output logic                  fall_out
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;

    wire [DIV_W-1:0] half = div_in >> 1;
    wire             wrap = sync_in || (cnt_r >= DIV_W'(div_in - 1'b1));

    assign cnt_nxt = wrap ? '0 : DIV_W'(cnt_r + 1'b1);

    // odd divisors: short high phase
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            cnt_r    <= '0;
            lvl_out  <= 1'b0;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            lvl_out  <= (cnt_nxt < half);
            rise_out <= (cnt_nxt == '0);
            fall_out <= (cnt_nxt == half);
        end
    end
endmodule : pmp_clkgen

// *** testbench/pmp_mac_port_properties.sv ***
// concurrent checks on the pins of the mac-side port
`timescale 1ns/1ps
module pmp_mac_port_properties (
    input wire logic       sys_clk_in,
    input wire logic       srst_in,
    input wire logic [2:0] cfg_strap_in,
    input wire logic       eee_en_in,
    input wire logic       full_duplex_in,
    input wire logic       link_up_in,
    input wire logic       tx_en_in,
    input wire logic [3:0] tx_data_in,
    input wire logic       tx_clk_out,
    input wire logic       rx_clk_out,
    input wire logic       rx_dv_out,
    input wire logic [3:0] rx_data_out,
    input wire logic       crs_out,
    input wire logic       col_out,
    input wire logic       ref_clk_out,
    input wire logic       rmii_mode_out,
    input wire logic       ref50_mode_out,
    input wire logic       rx_clk_recov_out,
    input wire logic       ln_rx_valid_in,
    input wire logic [2:0] ln_rx_kind_in,
    input wire logic       ln_rx_ready_out,
    input wire logic       ln_tx_valid_out,
    input wire logic [3:0] ln_tx_nib_out,
    input wire logic       ln_tx_lpi_out
);
    // mode flags settle after reset
    logic [2:0] up_cnt_r;
    logic       up_r;
    logic       taken;
    assign up_r  = up_cnt_r[2];
    assign taken = ln_rx_valid_in && ln_rx_ready_out && link_up_in;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) up_cnt_r <= 3'h0;
        else if (!up_r) up_cnt_r <= up_cnt_r + 3'h1;
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);

    a_tx_clk_runs: assert property (
        up_r && !rmii_mode_out |-> ##[1:30] $changed(tx_clk_out))
        else $error("txc stall");
    a_tx_nib_taken: assert property (
        $rose(tx_clk_out) && $past(tx_en_in) && !rmii_mode_out
        |-> ln_tx_valid_out && ln_tx_nib_out == $past(tx_data_in))
        else $error("tx nibble");
    a_tx_one_pulse: assert property (
        ln_tx_valid_out |=> !ln_tx_valid_out)
        else $error("tx pulse");
    a_rx_idle_code: assert property (
        up_r && !rx_dv_out |-> rx_data_out inside {4'h0, 4'h1})
        else $error("idle code");
    a_dv_holds: assert property (
        $rose(rx_dv_out) |-> rx_dv_out [*4])
        else $error("dv short");
    a_crs_start: assert property (
        taken && ln_rx_kind_in == 3'h1 |=> crs_out)
        else $error("crs start");
    a_crs_end: assert property (
        taken && ln_rx_kind_in inside {3'h2, 3'h3} |=> !crs_out)
        else $error("crs end");
    a_col_half: assert property (
        col_out |-> !$past(full_duplex_in) && !$past(rmii_mode_out))
        else $error("col duplex");
    a_rmii_quiet: assert property (
        rmii_mode_out && $past(rmii_mode_out, 2) |-> !tx_clk_out
        && !rx_clk_out && !col_out && rx_data_out[3:2] == 2'h0)
        else $error("rmii pins");
    a_strap_mode: assert property (
        up_r |-> rmii_mode_out == (cfg_strap_in == 3'h1))
        else $error("strap mode");
    a_ref50_mode: assert property (
        ref50_mode_out |-> rmii_mode_out && !ref_clk_out)
        else $error("ref clk");
    a_recov_link: assert property (
        rx_clk_recov_out |-> $past(link_up_in) || $past(link_up_in, 2))
        else $error("recov link");
    a_lpi_eee: assert property (
        $rose(ln_tx_lpi_out) |-> $past(eee_en_in))
        else $error("lpi eee");
endmodule : pmp_mac_port_properties

bind pmp_mac_port pmp_mac_port_properties chk_inst (.*);

// *** testbench/pmp_mac_model.sv ***
// mac model driving the transmit pins from the port's transmit clock
`timescale 1ns/1ps
module pmp_mac_model (
    // clock and port pins
    input  wire logic  sys_clk_in,
    input  wire logic  tx_clk_in,
    input  wire logic  eee_in,
    output logic       tx_en_out,
    output logic [3:0] tx_data_out,
    output logic       tx_err_out,
    // set when the transmit clock never falls
    output logic       hang_out
);
    initial begin
        tx_en_out   = 1'b0;
        tx_data_out = 4'h0;
        tx_err_out  = 1'b0;
        hang_out    = 1'b0;
    end
    // change in the low phase, settled by the next rise
    task automatic tx_fall();
        int n;
        for (n = 0; n < 120 && !tx_clk_in; n++) @(posedge sys_clk_in) #1;
        for (n = 0; n < 120 && tx_clk_in; n++) @(posedge sys_clk_in) #1;
        if (n == 120) hang_out = 1'b1;
    endtask : tx_fall
    task automatic send(input int len, input logic [3:0] base);
        for (int i = 0; i < len; i++) begin
            tx_fall();
            tx_en_out   = 1'b1;
            tx_data_out = base + 4'(i);
        end
        tx_fall();
        tx_en_out   = 1'b0;
        tx_data_out = eee_in ? 4'h1 : 4'h0;
    endtask : send
    task automatic lpi(input logic on);
        tx_fall();
        tx_err_out = on & eee_in;
    endtask : lpi
endmodule : pmp_mac_model

// *** testbench/tb_pmp_mac_port.sv ***
// self-checking bench for the mac-side port
`timescale 1ns/1ps
module tb_pmp_mac_port;
    localparam int K100 = pmp_pkg::SYS_CLK_KHZ / pmp_pkg::NIB_100_KHZ;
    localparam int K10  = pmp_pkg::SYS_CLK_KHZ / pmp_pkg::NIB_10_KHZ;
    logic       sys_clk_in = 1'b0, srst_in = 1'b1;
    logic [2:0] cfg_strap_in = 3'h0, ln_rx_kind_in = 3'h0;
    logic       ref50_sel_in = 1'b0, xtal_is_50m_in = 1'b0;
    logic       eee_en_in = 1'b0, full_duplex_in = 1'b0;
    logic       link_up_in = 1'b1, speed_100_in = 1'b1;
    logic       ln_rx_valid_in = 1'b0, ln_rx_err_in = 1'b0;
    logic       ln_rx_sfd_in = 1'b0;
    logic [3:0] ln_rx_nib_in = 4'h0, tx_data_in, rx_data_out, ln_tx_nib_out;
    logic       tx_en_in, tx_err_in, tx_clk_out, rx_clk_out, rx_dv_out;
    logic       rx_err_out, crs_out, col_out, ref_clk_out, rmii_mode_out;
    logic       ref50_mode_out, rx_clk_recov_out, ln_rx_ready_out;
    logic       ln_tx_valid_out, ln_tx_lpi_out, hang;
    logic [4:0] rx_got[$];
    logic [3:0] tx_got[$];
    logic       rxc_q = 1'b0, col_seen = 1'b0, full_seen = 1'b0;
    int         bad_count = 0, num_checks = 0;

    always #4 sys_clk_in = ~sys_clk_in;

    pmp_mac_port pmp_mac_port_inst (.*, .ln_rec_tick_in(1'b0));
    pmp_mac_model pmp_mac_model_inst (.sys_clk_in, .tx_clk_in(tx_clk_out),
        .eee_in(eee_en_in), .tx_en_out(tx_en_in), .tx_data_out(tx_data_in),
        .tx_err_out(tx_err_in), .hang_out(hang));

    always @(posedge sys_clk_in) begin
        rxc_q <= rx_clk_out;
        if (ln_tx_valid_out === 1'b1) tx_got.push_back(ln_tx_nib_out);
        if (rx_clk_out && !rxc_q && rx_dv_out === 1'b1)
            rx_got.push_back({rx_err_out, rx_data_out});
        if (col_out === 1'b1) col_seen <= 1'b1;
        if (ln_rx_valid_in && ln_rx_ready_out === 1'b0) full_seen <= 1'b1;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp,
                           input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask : chk_val
    task automatic chk_flag(input logic got, input logic exp,
                            input string what);
        chk_val({7'h0, got}, {7'h0, exp}, what);
    endtask : chk_flag
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in) #1;
    endtask : cyc
    // returns just after the taking edge
    task automatic push(input logic [2:0] kind, input logic [3:0] nib,
                        input logic err = 1'b0, input logic sfd = 1'b0);
        int n;
        ln_rx_valid_in = 1'b1;
        ln_rx_kind_in  = kind;
        ln_rx_nib_in   = nib;
        ln_rx_err_in   = err;
        ln_rx_sfd_in   = sfd;
        for (n = 0; n < 400 && ln_rx_ready_out !== 1'b1; n++) cyc(1);
        if (n == 400) begin
            chk_flag(1'b0, 1'b1, "ready");
            tally_and_finish();
        end
        cyc(1);
    endtask : push
    task automatic period(input logic rx, input int exp);
        int   n;
        int   t0;
        logic now;
        logic prev;
        t0 = -1;
        prev = rx ? rx_clk_out : tx_clk_out;
        for (n = 0; n < 300; n++) begin
            cyc(1);
            now = rx ? rx_clk_out : tx_clk_out;
            if (now && !prev && t0 >= 0) break;
            if (now && !prev) t0 = n;
            prev = now;
        end
        chk_val(8'(n - t0), 8'(exp), "period");
    endtask : period
    // wait for n nibbles, then room for extras
    task automatic drain(input int n);
        for (int k = 0; k < 4000 && rx_got.size() < n; k++) cyc(1);
        cyc(150);
        chk_val(8'(rx_got.size()), 8'(n), "count");
        chk_flag(rx_dv_out, 1'b0, "dv end");
        chk_val({4'h0, rx_data_out}, 8'h00, "idle");
    endtask : drain

    initial begin
        repeat (12) @(posedge sys_clk_in);
        #1 srst_in = 1'b0;
        cyc(4);
        chk_flag(rmii_mode_out, 1'b0, "mii");
        period(1'b0, K100);
        period(1'b1, K100);
        chk_flag(rx_clk_recov_out, 1'b1, "cdr");
        speed_100_in = 1'b0;
        period(1'b0, K100);
        speed_100_in = 1'b1;
        push(pmp_pkg::KIND_JK, 4'h0);
        ln_rx_valid_in = 1'b0;
        cyc(1);
        chk_flag(crs_out, 1'b1, "crs jk");
        // tx overlaps a frame long enough to fill the fifo
        fork
            pmp_mac_model_inst.send(8, 4'h3);
            for (int i = 0; i < 44; i++) push(3'h0, 4'(i), i == 20);
        join
        push(pmp_pkg::KIND_TR, 4'h0);
        ln_rx_valid_in = 1'b0;
        drain(44);
        for (int i = 0; i < 44; i++)
            chk_val(8'(rx_got[i]), {3'h0, i == 20, 4'(i)}, "rx");
        chk_flag(full_seen, 1'b1, "full");
        chk_flag(col_seen, 1'b1, "col");
        chk_val(8'(tx_got.size()), 8'h08, "tx n");
        for (int i = 0; i < 8; i++)
            chk_val({4'h0, tx_got[i]}, 8'(3 + i), "tx");
        link_up_in = 1'b0;
        speed_100_in = 1'b0;
        full_duplex_in = 1'b1;
        cyc(4);
        link_up_in = 1'b1;
        cyc(4);
        period(1'b0, K10);
        period(1'b1, K10);
        chk_flag(rx_clk_recov_out, 1'b0, "ref");
        rx_got.delete();
        push(3'h0, 4'h5);
        ln_rx_valid_in = 1'b0;
        cyc(1);
        chk_flag(crs_out, 1'b1, "crs pre");
        push(3'h0, 4'h5);
        push(3'h0, pmp_pkg::SFD_FIRST_NIB, 1'b0, 1'b1);
        push(3'h0, 4'hd);
        push(3'h0, 4'h3);
        push(pmp_pkg::KIND_TR, 4'h0);
        ln_rx_valid_in = 1'b0;
        drain(3);
        chk_val(8'(rx_got[0]), 8'h05, "sfd0");
        chk_val(8'(rx_got[1]), 8'h0d, "sfd1");
        eee_en_in = 1'b1;
        push(pmp_pkg::KIND_LPI, 4'h0);
        ln_rx_valid_in = 1'b0;
        cyc(120);
        chk_val({4'h0, rx_data_out}, 8'h01, "lpi");
        chk_flag(rx_err_out, 1'b1, "lpi err");
        pmp_mac_model_inst.lpi(1'b1);
        cyc(60);
        chk_flag(ln_tx_lpi_out, 1'b1, "tx lpi");
        pmp_mac_model_inst.lpi(1'b0);
        push(pmp_pkg::KIND_IDLE, 4'h0);
        ln_rx_valid_in = 1'b0;
        cyc(120);
        chk_flag(rx_err_out, 1'b0, "lpi off");
        eee_en_in = 1'b0;
        chk_flag(hang, 1'b0, "hang");
        srst_in = 1'b1;
        cfg_strap_in = pmp_pkg::STRAP_RMII;
        cyc(12);
        srst_in = 1'b0;
        cyc(60);
        chk_flag(rmii_mode_out, 1'b1, "rmii");
        chk_flag(ref50_mode_out, 1'b0, "25m");
        chk_flag(tx_clk_out, 1'b0, "txc off");
        ref50_sel_in = 1'b1;
        xtal_is_50m_in = 1'b1;
        cyc(6);
        chk_flag(ref50_mode_out, 1'b1, "50m");
        tally_and_finish();
    end
endmodule : tb_pmp_mac_port
